//--- osm_pkg.sv
package osm_pkg;

   // Register map, 7-bit word addresses
   localparam logic [6:0]  OSM_ADDR_TEMP      = 7'h00;
   localparam logic [6:0]  OSM_ADDR_CORE      = 7'h01;
   localparam logic [6:0]  OSM_ADDR_AUX       = 7'h02;
   localparam logic [6:0]  OSM_ADDR_EXT       = 7'h03;
   localparam logic [6:0]  OSM_ADDR_CFG0      = 7'h40;
   localparam logic [6:0]  OSM_ADDR_CFG1      = 7'h41;
   localparam logic [6:0]  OSM_ADDR_CFG2      = 7'h42;
   localparam logic [6:0]  OSM_ADDR_CTRL_BASE = 7'h40;

   // Configuration register 0 fields
   localparam int          OSM_CFG0_CH_LSB    = 0;
   localparam int          OSM_CFG0_DIFF_BIT  = 10;
   localparam int          OSM_CFG0_EVENT_BIT = 9;
   localparam int          OSM_CFG0_AVG_LSB   = 12;
   // Configuration register 1 fields
   localparam int          OSM_CFG1_SEQ_LSB   = 12;
   localparam logic [3:0]  OSM_SEQ_SINGLE     = 4'h3;
   localparam logic [3:0]  OSM_SEQ_SAFE       = 4'h0;

   // Reset values of configuration registers
   localparam logic [15:0] OSM_CFG0_RST       = 16'h0000;
   localparam logic [15:0] OSM_CFG1_RST       = 16'h0000;
   localparam logic [15:0] OSM_CFG2_RST       = 16'h0000;

   // Channel numbers
   localparam logic [4:0]  OSM_CH_TEMP        = 5'h00;
   localparam logic [4:0]  OSM_CH_CORE        = 5'h01;
   localparam logic [4:0]  OSM_CH_AUX         = 5'h02;
   localparam logic [4:0]  OSM_CH_EXT         = 5'h03;

   // Converter code, full scale and result alignment
   localparam int          OSM_CODE_W         = 10;
   localparam logic [9:0]  OSM_CODE_FULL      = 10'h3FF;
   localparam int          OSM_REG_W          = 16;
   localparam int          OSM_NUM_RESULTS    = 4;

   // Averaging: 0 = off, 1 = 16, 2 = 64, 3 = 256 samples
   localparam int          OSM_ACC_W          = 18;

   // Internal oscillator: conversion period
   localparam real         OSM_CONV_NS        = 1000.0;
   localparam real         OSM_CLK_NS         = 5.0;
   localparam int          OSM_CONV_CYC       = int'(OSM_CONV_NS / OSM_CLK_NS);
   localparam logic [7:0]  OSM_CONV_CNT       = 8'(OSM_CONV_CYC - 1);

   // Access port states
   typedef enum logic [2:0] {
      OSM_PS_IDLE = 3'b001,
      OSM_PS_WAIT = 3'b010,
      OSM_PS_DONE = 3'b100
   } osm_port_state_e;

endpackage

//--- osm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface osm_if;
   // Reconfiguration port (fabric)
   logic        rp_en;
   logic        rp_we;
   logic [6:0]  rp_addr;
   logic [15:0] rp_wdata;
   logic [15:0] rp_rdata;
   logic        rp_rdy;
   // Test access port register path
   logic        tap_en;
   logic        tap_we;
   logic [6:0]  tap_addr;
   logic [15:0] tap_wdata;
   logic [15:0] tap_rdata;
   logic        tap_rdy;
   // Configuration state and converter
   logic        cfg_done;
   logic        cfg_full_load;
   logic [15:0] cfg_init0;
   logic [15:0] cfg_init1;
   logic [15:0] cfg_init2;
   logic [9:0]  adc_code;
   logic        eoc;
   logic [4:0]  cur_channel;

   modport dev (
      input  rp_en, rp_we, rp_addr, rp_wdata, tap_en, tap_we, tap_addr, tap_wdata,
      input  cfg_done, cfg_full_load, cfg_init0, cfg_init1, cfg_init2, adc_code,
      output rp_rdata, rp_rdy, tap_rdata, tap_rdy, eoc, cur_channel
   );
   modport host (
      output rp_en, rp_we, rp_addr, rp_wdata, tap_en, tap_we, tap_addr, tap_wdata,
      output cfg_done, cfg_full_load, cfg_init0, cfg_init1, cfg_init2,
      input  rp_rdata, rp_rdy, tap_rdata, tap_rdy, eoc, cur_channel
   );
endinterface
`default_nettype wire

//--- osm_host.sv
`timescale 1ns/1ps
`default_nettype none
module osm_host (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset_n,
   // User request
   input  wire logic        i_req,
   input  wire logic        i_use_tap,
   input  wire logic        i_we,
   input  wire logic [6:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   // Configuration control
   input  wire logic        i_cfg_done,
   input  wire logic        i_cfg_full_load,
   input  wire logic [15:0] i_init0,
   input  wire logic [15:0] i_init1,
   input  wire logic [15:0] i_init2,
   // User answer
   output logic             o_busy,
   output logic             o_done,
   output logic [15:0]      o_rdata,
   output logic [9:0]       o_last_code,
   // Link
   osm_if.host              bus
);
   import osm_pkg::*;

   osm_port_state_e state_ff;
   logic            tap_ff;
   logic            we_ff;
   logic [6:0]      addr_ff;
   logic [15:0]     wdata_ff;
   logic            rdy;
   logic            rdy_seen_ff;

   ////////////////////////////////////////////////////////////////////////
   // One outstanding access on either path, the device answers one cycle on
   assign rdy = tap_ff ? bus.tap_rdy : bus.rp_rdy;

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff <= OSM_PS_IDLE;
      end else begin
         case (state_ff)
            OSM_PS_IDLE: if (i_req) state_ff <= OSM_PS_WAIT;
            OSM_PS_WAIT: if (rdy) state_ff <= OSM_PS_DONE;
            OSM_PS_DONE: state_ff <= OSM_PS_IDLE;
            default:     state_ff <= OSM_PS_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tap_ff   <= 1'b0;
         we_ff    <= 1'b0;
         addr_ff  <= 7'h00;
         wdata_ff <= 16'h0000;
      end else if (state_ff == OSM_PS_IDLE && i_req) begin
         tap_ff   <= i_use_tap;
         we_ff    <= i_we;
         addr_ff  <= i_addr;
         wdata_ff <= i_wdata;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 16'h0000;
      end else if (state_ff == OSM_PS_WAIT && rdy) begin
         o_rdata <= tap_ff ? bus.tap_rdata : bus.rp_rdata;
      end
   end

   // Temperature and supply codes are the upper ten bits of a result
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_last_code <= 10'h000;
      end else if (state_ff == OSM_PS_WAIT && rdy && !we_ff) begin
         o_last_code <= (tap_ff ? bus.tap_rdata[15:6] : bus.rp_rdata[15:6]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable is a one-cycle strobe at the entry into WAIT
   assign bus.tap_en        = (state_ff == OSM_PS_WAIT) && tap_ff && !rdy_seen_ff;
   assign bus.rp_en         = (state_ff == OSM_PS_WAIT) && !tap_ff && !rdy_seen_ff;
   assign bus.tap_we        = we_ff;
   assign bus.rp_we         = we_ff;
   assign bus.tap_addr      = addr_ff;
   assign bus.rp_addr       = addr_ff;
   assign bus.tap_wdata     = wdata_ff;
   assign bus.rp_wdata      = wdata_ff;
   assign bus.cfg_done      = i_cfg_done;
   assign bus.cfg_full_load = i_cfg_full_load;
   assign bus.cfg_init0     = i_init0;
   assign bus.cfg_init1     = i_init1;
   assign bus.cfg_init2     = i_init2;
   assign o_busy            = (state_ff != OSM_PS_IDLE);
   assign o_done            = (state_ff == OSM_PS_DONE);

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdy_seen_ff <= 1'b0;
      end else begin
         rdy_seen_ff <= (state_ff == OSM_PS_WAIT);
      end
   end

endmodule // osm_host
`default_nettype wire

//--- osm_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Starts in safe mode without configuration
// - Usable after clearing, ignores configuration hold
// - Safe mode sequences temperature, core, auxiliary
// - Safe mode unaffected until configuration completes
// - Full configuration overwrites pre-configuration settings
// - Internal oscillator times conversions without clock
// - Test port reads every register, writes configuration registers always
// - Test port access stays after configuration
// - Unsigned ten-bit code, all ones full scale
// - Written configuration selects unipolar or differential
// - Single channel mode selects channel, sampling
// - Host converts temperature code to Celsius
// - Temperature averaging up to 256 samples
// - Temperature reading stored at 00h
// - Supply averaging up to 256 samples
// - Core at 01h, auxiliary at 02h
// - Host reads supply scale 0 to 3 V
// - Results sixteen bits, code MSB justified
// - End of conversion pulses on result write
module osm_dev (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset_n,
   // Converter status
   output logic             o_diff_mode,
   output logic             o_event_mode,
   output logic             o_safe_mode,
   // Link
   osm_if.dev               bus
);
   import osm_pkg::*;

   logic [15:0] cfg_ff [0:2];
   logic [15:0] res_ff [0:OSM_NUM_RESULTS-1];
   logic [7:0]  conv_cnt_ff;
   logic        conv_tick;
   logic [4:0]  chan_ff;
   logic [4:0]  nxt_chan;
   logic        single;
   logic [1:0]  avg_sel;
   logic [8:0]  avg_n;
   logic [OSM_ACC_W-1:0] acc_ff [0:2];
   logic [8:0]  cnt_ff [0:2];
   logic [3:0]  conv_wr;
   logic        eoc_ff;
   logic        tap_rdy_ff;
   logic        rp_rdy_ff;
   logic [15:0] tap_rdata_ff;
   logic [15:0] rp_rdata_ff;
   logic        tap_wr;
   logic        rp_wr;

   ////////////////////////////////////////////////////////////////////////
   // Safe mode holds until configuration is done; the config hold pins
   // never reach this block, so delaying configuration changes nothing
   assign o_safe_mode  = !bus.cfg_done;
   assign single       = !o_safe_mode && (cfg_ff[1][OSM_CFG1_SEQ_LSB +: 4] == OSM_SEQ_SINGLE);
   assign o_diff_mode  = cfg_ff[0][OSM_CFG0_DIFF_BIT];
   assign o_event_mode = cfg_ff[0][OSM_CFG0_EVENT_BIT];
   assign avg_sel      = o_safe_mode ? 2'h0 : cfg_ff[0][OSM_CFG0_AVG_LSB +: 2];

   always_comb begin
      case (avg_sel)
         2'h1:    avg_n = 9'd16;
         2'h2:    avg_n = 9'd64;
         2'h3:    avg_n = 9'd256;
         default: avg_n = 9'd1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion timer stands for the internal oscillator; it needs no
   // configured clock, so it runs from reset release
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         conv_cnt_ff <= OSM_CONV_CNT;
      end else if (conv_cnt_ff == 8'h00) begin
         conv_cnt_ff <= OSM_CONV_CNT;
      end else begin
         conv_cnt_ff <= conv_cnt_ff - 8'h01;
      end
   end
   assign conv_tick = (conv_cnt_ff == 8'h00);

   // Channel selection: safe sequence, or one configured channel
   always_comb begin
      if (single) begin
         nxt_chan = cfg_ff[0][OSM_CFG0_CH_LSB +: 5];
      end else if (chan_ff == OSM_CH_AUX) begin
         nxt_chan = OSM_CH_TEMP;
      end else begin
         nxt_chan = chan_ff + 5'h01;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         chan_ff <= OSM_CH_TEMP;
      end else if (conv_tick) begin
         chan_ff <= nxt_chan;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Averaging per on-chip sensor; the result only moves on a full count
   generate
      for (genvar g = 0; g < 3; g++) begin : g_avg
         logic [OSM_ACC_W-1:0] sum;
         logic                 full;
         assign sum  = acc_ff[g] + {8'h00, bus.adc_code};
         assign full = (cnt_ff[g] + 9'd1 == avg_n);
         assign conv_wr[g] = full;
         always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
            if (!i_reset_n) begin
               acc_ff[g] <= '0;
               cnt_ff[g] <= 9'd0;
               res_ff[g] <= 16'h0000;
            end else if (conv_tick && chan_ff == 5'(g)) begin
               if (full) begin
                  acc_ff[g] <= '0;
                  cnt_ff[g] <= 9'd0;
                  case (avg_sel)
                     2'h1:    res_ff[g] <= {sum[13:4], 6'h00};
                     2'h2:    res_ff[g] <= {sum[15:6], 6'h00};
                     2'h3:    res_ff[g] <= {sum[17:8], 6'h00};
                     default: res_ff[g] <= {sum[9:0], 6'h00};
                  endcase
               end else begin
                  acc_ff[g] <= sum;
                  cnt_ff[g] <= cnt_ff[g] + 9'd1;
               end
            end
         end
      end
   endgenerate

   // External pair is not averaged; full scale 3FF maps to 1 V differential
   assign conv_wr[3] = 1'b1;
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         res_ff[3] <= 16'h0000;
      end else if (conv_tick && chan_ff == OSM_CH_EXT) begin
         res_ff[3] <= {bus.adc_code, 6'h00};
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         eoc_ff <= 1'b0;
      end else begin
         // Channels with no result register write nothing, so they raise no pulse
         eoc_ff <= conv_tick && (chan_ff <= OSM_CH_EXT) && conv_wr[chan_ff[1:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers: both paths write; the test port wins a tie.
   // A full configuration reloads the configured values.
   assign tap_wr = bus.tap_en && bus.tap_we;
   assign rp_wr  = bus.rp_en && bus.rp_we && bus.cfg_done;

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_ff[0] <= OSM_CFG0_RST;
         cfg_ff[1] <= OSM_CFG1_RST;
         cfg_ff[2] <= OSM_CFG2_RST;
      end else if (bus.cfg_full_load) begin
         cfg_ff[0] <= bus.cfg_init0;
         cfg_ff[1] <= bus.cfg_init1;
         cfg_ff[2] <= bus.cfg_init2;
      end else if (tap_wr && bus.tap_addr >= OSM_ADDR_CFG0 && bus.tap_addr <= OSM_ADDR_CFG2) begin
         cfg_ff[bus.tap_addr[1:0]] <= bus.tap_wdata;
      end else if (rp_wr && bus.rp_addr >= OSM_ADDR_CFG0 && bus.rp_addr <= OSM_ADDR_CFG2) begin
         cfg_ff[bus.rp_addr[1:0]] <= bus.rp_wdata;
      end
   end

   // Read mux shared by both paths; unmapped addresses read zero
   function automatic logic [15:0] rd_mux(input logic [6:0] a);
      logic [15:0] d;
      d = 16'h0000;
      if (a < OSM_ADDR_EXT + 7'h01) begin
         d = res_ff[a[1:0]];
      end else if (a >= OSM_ADDR_CFG0 && a <= OSM_ADDR_CFG2) begin
         d = cfg_ff[a[1:0]];
      end
      return d;
   endfunction

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tap_rdy_ff   <= 1'b0;
         tap_rdata_ff <= 16'h0000;
      end else begin
         tap_rdy_ff   <= bus.tap_en;
         if (bus.tap_en) tap_rdata_ff <= rd_mux(bus.tap_addr);
      end
   end

   // Fabric port answers only once configured
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rp_rdy_ff   <= 1'b0;
         rp_rdata_ff <= 16'h0000;
      end else begin
         rp_rdy_ff   <= bus.rp_en && bus.cfg_done;
         if (bus.rp_en) rp_rdata_ff <= rd_mux(bus.rp_addr);
      end
   end

   assign bus.tap_rdy     = tap_rdy_ff;
   assign bus.tap_rdata   = tap_rdata_ff;
   assign bus.rp_rdy      = rp_rdy_ff;
   assign bus.rp_rdata    = rp_rdata_ff;
   assign bus.eoc         = eoc_ff;
   assign bus.cur_channel = chan_ff;

endmodule // osm_dev
`default_nettype wire

//--- osm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module osm_monitor (
   // Clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset_n,
   // Register paths
   input  wire logic        rp_en,
   input  wire logic        rp_rdy,
   input  wire logic        tap_en,
   input  wire logic        tap_we,
   input  wire logic [6:0]  tap_addr,
   input  wire logic [15:0] tap_rdata,
   input  wire logic        tap_rdy,
   // Configuration state and converter
   input  wire logic        cfg_done,
   input  wire logic        eoc,
   input  wire logic [4:0]  cur_channel
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////////////////////////////////////////
   // Cycles since last eoc, held at zero while cfg_done; saturates so a stalled converter stays visible
   logic [8:0] gap_ff;
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n)
         gap_ff <= 9'h000;
      else if (eoc || cfg_done)
         gap_ff <= 9'h000;
      else if (gap_ff != 9'h1FF)
         gap_ff <= gap_ff + 9'h001;
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_tap_answer;
      tap_en |=> tap_rdy;
   endproperty
   a_tap_answer: assert property (p_tap_answer) else $error("test path access not answered");
   property p_rdy_pulse;
      tap_rdy |=> !tap_rdy;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("test path ready longer than one cycle");
   property p_tap_post_cfg;
      cfg_done && tap_en |=> tap_rdy;
   endproperty
   a_tap_post_cfg: assert property (p_tap_post_cfg) else $error("test path lost after configuration");
   property p_rp_refused;
      rp_en && !cfg_done |=> !rp_rdy;
   endproperty
   a_rp_refused: assert property (p_rp_refused) else $error("fabric port answered before configuration");
   property p_rp_answer;
      rp_en && cfg_done |=> rp_rdy;
   endproperty
   a_rp_answer: assert property (p_rp_answer) else $error("fabric port not answered after configuration");
   property p_eoc_pulse;
      eoc |=> !eoc [*8];
   endproperty
   a_eoc_pulse: assert property (p_eoc_pulse) else $error("end of conversion not a single pulse");
   // Margin of ten cycles over the 200-cycle period covers the first tick after reset
   property p_eoc_gap;
      !cfg_done |-> gap_ff <= 9'h0D2;
   endproperty
   a_eoc_gap: assert property (p_eoc_gap) else $error("safe mode conversions stalled");
   property p_seq;
      !cfg_done && $changed(cur_channel) |->
         cur_channel == (($past(cur_channel) == 5'h02) ? 5'h00 : $past(cur_channel) + 5'h01);
   endproperty
   a_seq: assert property (p_seq) else $error("safe mode channel order broken");
   property p_code_lsb;
      tap_rdy && $past(tap_en) && !$past(tap_we) && ($past(tap_addr) <= 7'h03) |-> tap_rdata[5:0] == 6'h00;
   endproperty
   a_code_lsb: assert property (p_code_lsb) else $error("result low bits not zero");
   c_eoc: cover property (eoc);
   c_tap_write: cover property (tap_en && tap_we);
   c_rp_read: cover property (rp_rdy);
endmodule // osm_monitor
`default_nettype wire

//--- on_chip_sensor_adc_readout_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module on_chip_sensor_adc_readout_tb_top;
   import osm_pkg::*;
   localparam int CONV = 200;
   logic        clk_sys;
   logic        reset_n;
   logic        req, use_tap, we, cfg_done, full_load;
   logic [6:0]  addr;
   logic [15:0] wdata, init0, init1, init2, rdata, got;
   logic        busy, done, diff_mode, event_mode, safe_mode;
   logic [9:0]  last_code, newc;
   logic [4:0]  ch;
   int          failures;
   int          checks;
   osm_if bus_if ();
   ////////////////////////////////////////////////////////////////////////////
   osm_host u_osm_host (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_req(req), .i_use_tap(use_tap),
      .i_we(we), .i_addr(addr), .i_wdata(wdata), .i_cfg_done(cfg_done), .i_cfg_full_load(full_load),
      .i_init0(init0), .i_init1(init1), .i_init2(init2), .o_busy(busy), .o_done(done), .o_rdata(rdata),
      .o_last_code(last_code), .bus(bus_if.host));
   osm_dev u_osm_dev (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .o_diff_mode(diff_mode),
      .o_event_mode(event_mode), .o_safe_mode(safe_mode), .bus(bus_if.dev));
   osm_monitor u_osm_monitor (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .rp_en(bus_if.rp_en),
      .rp_rdy(bus_if.rp_rdy), .tap_en(bus_if.tap_en), .tap_we(bus_if.tap_we), .tap_addr(bus_if.tap_addr),
      .tap_rdata(bus_if.tap_rdata), .tap_rdy(bus_if.tap_rdy), .cfg_done(bus_if.cfg_done),
      .eoc(bus_if.eoc), .cur_channel(bus_if.cur_channel));
   ////////////////////////////////////////////////////////////////////////////
   always #2.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // One access through the host; waits for the done pulse under a bound
   task automatic acc(input logic tap, input logic w, input logic [6:0] a, input logic [15:0] d);
      int n;
      @(posedge clk_sys);
      req <= 1'b1;
      use_tap <= tap;
      we <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      req <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (done !== 1'b1 && n < 10);
      if (done !== 1'b1) begin
         failures++;
         $display("[FAIL] t=%0t access never completed", $time);
         wrap_up();
      end
      got = rdata;
   endtask
   task automatic conv(input int n);
      repeat (n * CONV) @(posedge clk_sys);
   endtask
   task automatic set_code(input logic [9:0] c);
      @(posedge clk_sys);
      bus_if.adc_code <= c;
   endtask
   task automatic do_reset;
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Fabric access before configuration hangs the host, so a reset clears it
   task automatic t_refused;
      @(posedge clk_sys);
      req <= 1'b1;
      use_tap <= 1'b0;
      we <= 1'b0;
      addr <= OSM_ADDR_CFG0;
      @(posedge clk_sys);
      req <= 1'b0;
      repeat (10) @(posedge clk_sys);
      #1 chk(16'(busy), 16'h0001);
      do_reset();
      #1 chk(16'(safe_mode), 16'h0001);
      acc(1'b1, 1'b0, OSM_ADDR_CFG0, 16'h0000);
      chk(got, OSM_CFG0_RST);
   endtask
   task automatic t_safe;
      set_code(OSM_CODE_FULL);
      conv(5);
      for (int i = 0; i < 3; i++) begin
         acc(1'b1, 1'b0, 7'(i), 16'h0000);
         chk(got, 16'hFFC0);
      end
      chk({6'h00, last_code}, {6'h00, OSM_CODE_FULL});
      acc(1'b1, 1'b1, OSM_ADDR_TEMP, 16'h1234);
      acc(1'b1, 1'b0, OSM_ADDR_TEMP, 16'h0000);
      chk(got, 16'hFFC0);
   endtask
   task automatic t_cfg;
      acc(1'b1, 1'b1, OSM_ADDR_CFG0, 16'h0600);
      chk(16'(diff_mode), 16'h0001);
      chk(16'(event_mode), 16'h0001);
      acc(1'b1, 1'b0, OSM_ADDR_CFG0, 16'h0000);
      chk(got, 16'h0600);
      set_code(10'h155);
      conv(5);
      for (int i = 0; i < 3; i++) begin
         acc(1'b1, 1'b0, 7'(i), 16'h0000);
         chk(got, 16'h5540);
      end
   endtask
   task automatic t_load;
      @(posedge clk_sys);
      init0 <= 16'h0000;
      init1 <= 16'h3000;
      full_load <= 1'b1;
      @(posedge clk_sys);
      full_load <= 1'b0;
      acc(1'b1, 1'b0, OSM_ADDR_CFG0, 16'h0000);
      chk(got, 16'h0000);
      acc(1'b1, 1'b0, OSM_ADDR_CFG1, 16'h0000);
      chk(got, 16'h3000);
      chk(16'(diff_mode), 16'h0000);
      @(posedge clk_sys);
      cfg_done <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 chk(16'(safe_mode), 16'h0000);
      acc(1'b1, 1'b0, OSM_ADDR_CFG1, 16'h0000);
      chk(got, 16'h3000);
      acc(1'b0, 1'b0, OSM_ADDR_CFG1, 16'h0000);
      chk(got, 16'h3000);
   endtask
   task automatic t_single;
      acc(1'b0, 1'b1, OSM_ADDR_CFG0, {11'h000, OSM_CH_EXT});
      set_code(10'h2AA);
      conv(5);
      acc(1'b0, 1'b0, OSM_ADDR_EXT, 16'h0000);
      chk(got, 16'hAA80);
      chk(16'(bus_if.cur_channel), 16'(OSM_CH_EXT));
   endtask
   // Averaging over 16: nothing new before the count completes, then the new level
   // Temperature still holds its safe-mode 155; core took the first single-mode tick at 2AA
   task automatic t_avg;
      for (int i = 0; i < 2; i++) begin
         ch = (i == 0) ? OSM_CH_TEMP : OSM_CH_CORE;
         newc = (i == 0) ? 10'h0F0 : 10'h30F;
         set_code(newc);
         acc(1'b0, 1'b1, OSM_ADDR_CFG0, 16'h1000 | {11'h000, ch});
         conv(8);
         acc(1'b0, 1'b0, {2'b00, ch}, 16'h0000);
         chk(got, (i == 0) ? 16'h5540 : 16'hAA80);
         conv(40);
         acc(1'b0, 1'b0, {2'b00, ch}, 16'h0000);
         chk(got, {newc, 6'h00});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      {req, use_tap, we, cfg_done, full_load} = 5'h00;
      addr = 7'h00;
      {wdata, init0, init1, init2} = 64'h0;
      bus_if.adc_code = 10'h000;
      failures = 0;
      checks = 0;
      do_reset();
      t_refused();
      t_safe();
      t_cfg();
      t_load();
      t_single();
      t_avg();
      wrap_up();
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      failures++;
      $display("[FAIL] t=%0t run limit reached", $time);
      wrap_up();
   end
endmodule // on_chip_sensor_adc_readout_tb_top
`default_nettype wire
